// ==== core/supply_monitor_map.svh ====
// constants for the supply monitor: register fields, reset values, timing counts
// assumes a 10 MHz system clock; comparator levels arrive as digital inputs
// Contract
// R1 - fault pin low, stages off outside window
// R2 - internal faults force stages off regardless pin
// R3 - pin-driven channel eight only 3.5V shutdown
// R4 - undervoltage recovery releases pin after filter
// R5 - overvoltage recovery: filter, or clearing write
// R6 - bit 5 selects overvoltage latching, reset 1
// R7 - bit 7 zero selects threshold test mode
// R8 - bit 6 picks lower or upper test
// R9 - bit 2 reflects fault pin level
// R10 - bit 1 low means undervoltage present
// R11 - bit 0 low means overvoltage or stored
// R12 - upper bits 000 lower overvoltage threshold
// R13 - upper bits 010 raise undervoltage threshold
// R14 - upper bits 110 end test mode
// R15 - latched clear only after overvoltage gone
// R16 - monitoring leaves other registers untouched
// R17 - supply shutdown makes no diagnostic entry
// R18 - controller clears diagnostics after overvoltage
// R19 - diagnostic filter restarts on ground-threshold crossing
// R20 - clear command: ground/open to ok, battery stays
// R21 - switching starts at select or sync rising edge
// R22 - paralleled stages switched together by controller
// R23 - stored overvoltage survives external reset pin
// R24 - stages resume 250 us after supply returns
// R25 - recovery filter time is a parameter
`ifndef SUPPLY_MONITOR_MAP_SVH
`define SUPPLY_MONITOR_MAP_SVH
`define SM_BIT_TEST_N      7
`define SM_BIT_TEST_LOWER  6
`define SM_BIT_OV_LATCH    5
`define SM_BIT_PIN_LEVEL   2
`define SM_BIT_NO_UV       1
`define SM_BIT_NO_OV       0
`define SM_CFG_RESET       3'h7
`define SM_CFG_CLEAR       3'h6
`define SM_STATUS_RESET    8'hE0
`define SM_CLK_HZ          10000000
`define SM_RESUME_US       250
`define SM_RESUME_CYC      (`SM_RESUME_US * (`SM_CLK_HZ / 1000000))
`define SM_FILTER_CYC      16
`define SM_DIAG_FILTER_CYC 32
`endif

// ==== core/supply_monitor_pkg.sv ====
// types for the supply monitor
// assumes the map header for numeric constants
package supply_monitor_pkg;
   typedef struct packed {
      logic test_n;     // 0 = threshold test
      logic test_lower; // 1 = lower threshold under test
      logic ov_latch;   // 1 = latch overvoltage
   } cfg_t;
   typedef enum logic [2:0] {
      DG_OK  = 3'h1,
      DG_SCG = 3'h2,
      DG_OL  = 3'h4
   } diag_t;
endpackage : supply_monitor_pkg

// ==== core/supply_monitor_shutdown.sv ====
// supply monitor: fault pin, stage shutdown, status/config register, diag state
// assumes comparator outputs and serial decoding arrive synchronous to clk_in
`timescale 1ns/1ps
`include "supply_monitor_map.svh"
module supply_monitor_shutdown #(
   parameter int FILTER_CYC = `SM_FILTER_CYC,   // recovery filter length
   parameter int RESUME_CYC = `SM_RESUME_CYC,   // stage resume delay
   parameter int DIAG_CYC   = `SM_DIAG_FILTER_CYC,
   parameter int NCH        = 18
) (
   input  wire logic            clk_in,            // 10 MHz clock
   input  wire logic            nrst_in,           // async active-low reset
   input  wire logic            ext_rst_n_in,      // external reset pin, active low
   input  wire logic            uv_cmp_in,         // below lower limit
   input  wire logic            uv_test_cmp_in,    // below lower limit raised by 0.8V
   input  wire logic            ov_cmp_in,         // above upper limit
   input  wire logic            ov_test_cmp_in,    // above upper limit lowered by 0.8V
   input  wire logic            ch8_cut_cmp_in,    // below 3.5V
   input  wire logic            ch8_pin_ctrl_in,   // channel eight under pin control
   input  wire logic            fault_pin_in,      // sensed fault pin level
   input  wire logic            cfg_wr_in,         // status register write strobe
   input  wire logic [7:0]      cfg_wdata_in,      // written byte
   input  wire logic            diag_clear_in,     // diagnostic clear command
   input  wire logic [NCH-1:0]  scg_cross_in,      // output crossed ground threshold
   input  wire logic [NCH-1:0]  scg_level_in,      // output below ground threshold
   input  wire logic [NCH-1:0]  open_level_in,     // output at open-load level
   input  wire logic            spi_sel_in,        // serial slave select
   input  wire logic            sync_in,           // fast-bus sync input
   output logic                 fault_pin_o_out,   // fault pin driven value (low)
   output logic                 fault_pin_oe_out,  // fault pin driven
   output logic                 stages_off_out,    // all stages except eight off
   output logic                 ch8_off_out,       // channel eight off
   output logic [7:0]           status_out,        // register read value
   output logic [NCH-1:0]       diag_fault_out,    // per-channel diag fault
   output logic                 switch_start_out   // switching timing start pulse
);
   logic r1_q, rst_n;
   // release reset through two flops
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         r1_q  <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         r1_q  <= 1'b1;
         rst_n <= r1_q;
      end
   end

   supply_monitor_pkg::cfg_t cfg_q;
   logic uv_now, ov_now, ov_stored_q, fault_q;
   logic [15:0] filt_q, resume_q;
   logic sel_q, sync_q;

   // configuration bits; changed only by a status write, never by monitoring [R16]
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) cfg_q <= `SM_CFG_RESET; // [R6] [R7] [R8]
      else if (cfg_wr_in) cfg_q <= cfg_wdata_in[7:5];
   end

   // test mode shifts the threshold in use [R12] [R13] [R14]
   assign uv_now = uv_cmp_in
                 | (!cfg_q.test_n && cfg_q.test_lower && uv_test_cmp_in);
   assign ov_now = ov_cmp_in
                 | (!cfg_q.test_n && !cfg_q.test_lower && ov_test_cmp_in);

   // one decode of the clear code, shared by the latch and its check
   function automatic logic is_clear_code(input logic [2:0] top);
      return top == `SM_CFG_CLEAR;
   endfunction : is_clear_code

   // stored overvoltage: set dominates; ext reset pin not used here [R23] [R15]
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) ov_stored_q <= 1'b0;
      else if (ov_now) ov_stored_q <= 1'b1;
      else if (!cfg_q.ov_latch) ov_stored_q <= 1'b0;
      else if (cfg_wr_in && is_clear_code(cfg_wdata_in[7:5])) ov_stored_q <= 1'b0; // [R5]
   end

   // recovery filter; restarts while any fault stands [R4] [R5] [R25]
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         filt_q  <= 16'h0000;
         fault_q <= 1'b1;
      end else if (uv_now || ov_now || (cfg_q.ov_latch && ov_stored_q)) begin
         filt_q  <= 16'h0000;
         fault_q <= 1'b1; // [R1]
      end else if (fault_q) begin
         if (filt_q >= 16'(FILTER_CYC - 1)) fault_q <= 1'b0;
         else filt_q <= filt_q + 16'h0001;
      end
   end

   // pin drive and shutdown; internal fault overrides a high pin [R1] [R2]
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         fault_pin_o_out  <= 1'b0;
         fault_pin_oe_out <= 1'b1;
         stages_off_out   <= 1'b1;
         resume_q         <= 16'h0000;
      end else begin
         fault_pin_o_out  <= 1'b0;
         fault_pin_oe_out <= fault_q;
         if (fault_q || !fault_pin_in) begin
            stages_off_out <= 1'b1;
            resume_q       <= 16'h0000;
         end else if (resume_q >= 16'(RESUME_CYC - 1)) stages_off_out <= 1'b0; // [R24]
         else resume_q <= resume_q + 16'h0001;
      end
   end

   // channel eight: pin control only sees the 3.5V cut [R3]
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) ch8_off_out <= 1'b1;
      else if (ch8_pin_ctrl_in) ch8_off_out <= ch8_cut_cmp_in;
      else ch8_off_out <= fault_q || !fault_pin_in;
   end

   // status readback [R9] [R10] [R11]
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) status_out <= `SM_STATUS_RESET;
      else status_out <= {cfg_q, 2'b11, fault_pin_in, !uv_now, !(ov_now || ov_stored_q)};
   end

   // switching start at select or sync rising edge [R21]
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         sel_q <= 1'b1; // select idles high; a low reset value would fake an edge
         sync_q <= 1'b0;
         switch_start_out <= 1'b0;
      end else begin
         sel_q <= spi_sel_in;
         sync_q <= sync_in;
         switch_start_out <= (spi_sel_in && !sel_q) || (sync_in && !sync_q);
      end
   end

   // per-channel diagnostic state; supply shutdown masks new entries [R17]
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_diag
         supply_monitor_pkg::diag_t st_q;
         logic [7:0] dcnt_q;
         always_ff @(posedge clk_in or negedge rst_n) begin
            if (!rst_n) begin
               st_q   <= supply_monitor_pkg::DG_OK;
               dcnt_q <= 8'h00;
            end else if (diag_clear_in) begin
               st_q   <= supply_monitor_pkg::DG_OK; // [R20]
               dcnt_q <= 8'h00;
            end else if (scg_cross_in[g] || stages_off_out) begin
               dcnt_q <= 8'h00; // [R19]
            end else if (scg_level_in[g] || open_level_in[g]) begin
               if (dcnt_q >= 8'(DIAG_CYC - 1))
                  st_q <= scg_level_in[g] ? supply_monitor_pkg::DG_SCG
                                          : supply_monitor_pkg::DG_OL;
               else dcnt_q <= dcnt_q + 8'h01;
            end else dcnt_q <= 8'h00;
         end
         always_ff @(posedge clk_in or negedge rst_n) begin
            if (!rst_n) diag_fault_out[g] <= 1'b0;
            else diag_fault_out[g] <= (st_q != supply_monitor_pkg::DG_OK);
         end
         // shutdown holds the filter at zero and blocks any new entry
         a_diag_mask: assert property (@(posedge clk_in) disable iff (!rst_n) // [R17]
            (stages_off_out && (st_q == supply_monitor_pkg::DG_OK))
            |=> (st_q == supply_monitor_pkg::DG_OK)) else $error("diag entry in shutdown");
      end
   endgenerate

   // checks
   // own counts of clean cycles, so timing checks do not lean on the design's counters
   logic [15:0] quiet_q, clean_q;

   // cycles since the last fault cause; saturates instead of wrapping
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         quiet_q <= 16'h0000;
      end else if (uv_now || ov_now || (cfg_q.ov_latch && ov_stored_q)) begin
         quiet_q <= 16'h0000;
      end else if (quiet_q != 16'hFFFF) begin
         quiet_q <= quiet_q + 16'h0001;
      end
   end

   // cycles with the pin released and no internal fault
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         clean_q <= 16'h0000;
      end else if (fault_q || !fault_pin_in) begin
         clean_q <= 16'h0000;
      end else if (clean_q != 16'hFFFF) begin
         clean_q <= clean_q + 16'h0001;
      end
   end

   // a fault cause must pull the pin within two cycles
   a_fault_drive: assert property (@(posedge clk_in) disable iff (!rst_n) // [R1]
      (uv_now || ov_now) |=> ##1 fault_pin_oe_out) else $error("pin not pulled");

   // internal fault wins even over a pin held high
   a_stage_off: assert property (@(posedge clk_in) disable iff (!rst_n) // [R2]
      fault_q |=> stages_off_out) else $error("stages on in fault");

   // an external low on the pin also stops the stages
   a_pin_low_off: assert property (@(posedge clk_in) disable iff (!rst_n) // [R1]
      !fault_pin_in |=> stages_off_out) else $error("stages on with pin low");

   // channel eight under pin control ignores the normal window
   a_ch8_cut: assert property (@(posedge clk_in) disable iff (!rst_n) // [R3]
      (ch8_pin_ctrl_in && !ch8_cut_cmp_in) |=> !ch8_off_out) else $error("ch8 cut");

   // but still drops below its own low cut
   a_ch8_cut_on: assert property (@(posedge clk_in) disable iff (!rst_n) // [R3]
      (ch8_pin_ctrl_in && ch8_cut_cmp_in) |=> ch8_off_out) else $error("ch8 not cut");

   // latched overvoltage only leaves through a register write
   a_latch_hold: assert property (@(posedge clk_in) disable iff (!rst_n) // [R5]
      (cfg_q.ov_latch && ov_stored_q && !(cfg_wr_in)) |=> ov_stored_q)
      else $error("latch lost");

   // with latching off the stored flag follows the live condition
   a_unlatch_free: assert property (@(posedge clk_in) disable iff (!rst_n) // [R6]
      (!cfg_q.ov_latch && !ov_now) |=> !ov_stored_q) else $error("latch stuck");

   // external reset pin leaves the stored flag alone
   a_ext_keep: assert property (@(posedge clk_in) disable iff (!rst_n) // [R23]
      (!ext_rst_n_in && cfg_q.ov_latch && ov_stored_q && !cfg_wr_in) |=> ov_stored_q)
      else $error("stored ov lost on ext reset");

   a_set_wins: assert property (@(posedge clk_in) disable iff (!rst_n) // [R15]
      ov_now |=> ov_stored_q) else $error("set lost");

   // a clear that meets a live overvoltage is refused
   a_clear_blocked: assert property (@(posedge clk_in) disable iff (!rst_n) // [R15]
      (ov_now && cfg_wr_in && is_clear_code(cfg_wdata_in[7:5])) |=> ov_stored_q)
      else $error("clear beat set");

   // written mode bits land in one cycle
   a_cfg_store: assert property (@(posedge clk_in) disable iff (!rst_n) // [R7] [R8]
      cfg_wr_in |=> (3'(cfg_q) == $past(cfg_wdata_in[7:5]))) else $error("cfg not stored");

   // status bits against their sources
   a_status_ov: assert property (@(posedge clk_in) disable iff (!rst_n) // [R11]
      ov_stored_q |=> !status_out[`SM_BIT_NO_OV]) else $error("ov bit");

   a_status_uv: assert property (@(posedge clk_in) disable iff (!rst_n) // [R10]
      uv_now |=> !status_out[`SM_BIT_NO_UV]) else $error("uv bit");

   a_status_pin: assert property (@(posedge clk_in) disable iff (!rst_n) // [R9]
      1'b1 |=> (status_out[`SM_BIT_PIN_LEVEL] == $past(fault_pin_in)))
      else $error("pin bit");

   // threshold tests show up in the status bits
   a_test_upper: assert property (@(posedge clk_in) disable iff (!rst_n) // [R12]
      (!cfg_q.test_n && !cfg_q.test_lower && ov_test_cmp_in) |=> !status_out[`SM_BIT_NO_OV])
      else $error("upper test");

   a_test_lower: assert property (@(posedge clk_in) disable iff (!rst_n) // [R13]
      (!cfg_q.test_n && cfg_q.test_lower && uv_test_cmp_in) |=> !status_out[`SM_BIT_NO_UV])
      else $error("lower test");

   // pin release only after a full clean filter span
   a_filter_time: assert property (@(posedge clk_in) disable iff (!rst_n) // [R4]
      $fell(fault_q) |-> (quiet_q >= 16'(FILTER_CYC))) else $error("short filter");

   a_resume_gap: assert property (@(posedge clk_in) disable iff (!rst_n) // [R24]
      $fell(stages_off_out) |-> $past(!fault_q, 2)) else $error("early resume");

   // stages return only after the whole resume delay
   a_resume_time: assert property (@(posedge clk_in) disable iff (!rst_n) // [R24]
      $fell(stages_off_out) |-> (clean_q >= 16'(RESUME_CYC))) else $error("short resume");

   // a select rising edge starts the switching timing
   a_start_edge: assert property (@(posedge clk_in) disable iff (!rst_n) // [R21]
      (spi_sel_in && !sel_q) |=> switch_start_out) else $error("no start pulse");

   a_diag_clear: assert property (@(posedge clk_in) disable iff (!rst_n) // [R20]
      diag_clear_in |=> ##1 diag_fault_out == '0) else $error("clear");

   // main scenarios
   c_ov_event: cover property (@(posedge clk_in) disable iff (!rst_n) $rose(ov_stored_q));
   c_recover: cover property (@(posedge clk_in) disable iff (!rst_n) $fell(fault_q));
   c_test_mode: cover property (@(posedge clk_in) disable iff (!rst_n) !cfg_q.test_n);
   c_ov_clear: cover property (@(posedge clk_in) disable iff (!rst_n) $fell(ov_stored_q));
   c_diag_entry: cover property (@(posedge clk_in) disable iff (!rst_n) $rose(|diag_fault_out));
endmodule : supply_monitor_shutdown

// ==== verif/fault_pin_model.sv ====
// board model of the fault pin: pull-up, short to supply, external pull-low
// assumes the device only ever drives the pin low while its enable is high
`timescale 1ns/1ps
module fault_pin_model (
   input  wire logic drive_oe_in, // device pulls the pin low
   input  wire logic tie_hi_in,   // pin shorted to supply
   input  wire logic pull_lo_in,  // controller pulls the pin low
   output logic      pin_out      // resolved pin level
);
   // a short to supply beats any low driver; released pin floats high
   always_comb begin
      if (tie_hi_in) begin
         pin_out = 1'b1;
      end else begin
         pin_out = ~(drive_oe_in | pull_lo_in);
      end
   end
endmodule : fault_pin_model

// ==== verif/supply_monitor_shutdown_tb.sv ====
// self-checking bench for the supply monitor shutdown block
// assumes shortened filter counts; pin level resolved by fault_pin_model
`timescale 1ns/1ps
module supply_monitor_shutdown_tb;
   localparam int FC = 4; // short recovery filter
   localparam int RC = 8; // short resume delay
   logic       clk_in, nrst_in, ext_n, uv, uvt, ov, ovt, c8, c8p, wr, dclr, sel;
   logic       tie_hi, pull_lo, pin, oe, soff, c8off, po, sst, syn;
   logic [7:0] wd, st, rnd;
   logic [1:0] dg, lvl;
   logic [2:0] tops [3] = '{3'h0, 3'h2, 3'h6};
   int         n_errors, cmp_count;

   supply_monitor_shutdown #(.FILTER_CYC(FC), .RESUME_CYC(RC), .DIAG_CYC(4), .NCH(2)) dut (
      .clk_in(clk_in), .nrst_in(nrst_in), .ext_rst_n_in(ext_n), .uv_cmp_in(uv),
      .uv_test_cmp_in(uvt), .ov_cmp_in(ov), .ov_test_cmp_in(ovt), .ch8_cut_cmp_in(c8),
      .ch8_pin_ctrl_in(c8p), .fault_pin_in(pin), .cfg_wr_in(wr), .cfg_wdata_in(wd),
      .diag_clear_in(dclr), .scg_cross_in(2'h0), .scg_level_in(lvl),
      .open_level_in(2'h0), .spi_sel_in(sel), .sync_in(syn), .fault_pin_o_out(po),
      .fault_pin_oe_out(oe), .stages_off_out(soff), .ch8_off_out(c8off),
      .status_out(st), .diag_fault_out(dg), .switch_start_out(sst));
   fault_pin_model board (.drive_oe_in(oe), .tie_hi_in(tie_hi), .pull_lo_in(pull_lo),
      .pin_out(pin));

   // next random byte, taps chosen for a long cycle
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr
   // status bits 1:0 expected for a threshold test code
   function automatic logic [1:0] test_exp(input logic [2:0] top);
      return {top != 3'h2, top != 3'h0};
   endfunction : test_exp
   // one counted comparison; case inequality keeps unknowns from matching
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // pass n edges, then sample once the edge's updates have landed
   task automatic w(input int n);
      repeat (n) @(posedge clk_in);
      #10;
   endtask : w
   // status write: top bits choose the mode, low bits random
   task automatic wr_top(input logic [2:0] top);
      @(posedge clk_in);
      rnd <= lfsr(rnd);
      wd  <= {top, rnd[4:0]};
      sel <= rnd[7];
      wr  <= 1'b1;
      @(posedge clk_in);
      wr  <= 1'b0;
      w(4);
      chk(st[7:5], top);
   endtask : wr_top
   // single closing point for normal end and watchdog
   task automatic end_sim;
      $display("compares %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_sim

   // 10 MHz clock
   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end
   // watchdog: the sequence needs under two hundred cycles
   initial begin
      #300000;
      n_errors++;
      end_sim();
   end
   // main sequence; test comparators high as for a nominal supply
   initial begin
      {uv, ov, c8, c8p, wr, dclr, sel, tie_hi, pull_lo} = '0;
      {syn, lvl} = '0;
      {uvt, ovt, ext_n} = 3'h7;
      wd = 8'h00;
      rnd = 8'h17;
      n_errors = 0;
      cmp_count = 0;
      nrst_in = 1'b0;
      repeat (2) @(posedge clk_in);
      nrst_in <= 1'b1;
      w(FC + RC + 8);
      chk({soff, po, st}, 10'h0FF);
      @(posedge clk_in) uv <= 1'b1;
      w(4);
      chk({oe, soff, st[2:0], dg}, 7'h64);
      @(posedge clk_in) {uv, lvl} <= 3'h1; // ground level on channel zero while stages off
      w(FC - 2);
      chk(oe, 1'b1);
      w(8);
      chk({oe, soff, st[1]}, 3'h3);
      w(RC + 2);
      chk({soff, dg}, 3'h1);
      $display("undervoltage test done");
      // latched overvoltage outlives filter and external reset pin
      @(posedge clk_in) ov <= 1'b1;
      w(4);
      chk({oe, soff, st[0]}, 3'h6);
      @(posedge clk_in) ov <= 1'b0;
      w(FC + RC + 4);
      chk({oe, st[0]}, 2'h2);
      @(posedge clk_in) ext_n <= 1'b0;
      w(3);
      chk(st[0], 1'b0);
      @(posedge clk_in) {ext_n, ov} <= 2'h3;
      wr_top(3'h6);
      chk(st[0], 1'b0);
      @(posedge clk_in) ov <= 1'b0;
      w(FC + 6);
      chk({oe, st[0]}, 2'h1);
      @(posedge clk_in) {dclr, lvl} <= 3'h4;
      @(posedge clk_in) dclr <= 1'b0;
      w(2);
      chk(dg, 2'h0);
      wr_top(3'h7);
      $display("overvoltage test done");
      // threshold tests: upper, lower, then end of test
      for (int i = 0; i < 3; i++) begin
         wr_top(tops[i]);
         chk(st[1:0], test_exp(tops[i]));
      end
      wr_top(3'h7);
      w(FC + RC + 8);
      $display("threshold test done");
      // select rising edge, then sync rising edge, each starts one timing pulse
      @(posedge clk_in) {sel, syn} <= 2'h0;
      @(posedge clk_in) sel <= 1'b1;
      w(1);
      chk(sst, 1'b1);
      @(posedge clk_in) syn <= 1'b1;
      w(1);
      chk(sst, 1'b1);
      w(1);
      chk(sst, 1'b0);
      $display("start test done");
      // channel eight on pin control, pin shorted high, then pulled low
      @(posedge clk_in) {c8p, uv, tie_hi} <= 3'h7;
      w(4);
      chk({c8off, soff, st[2]}, 3'h3);
      @(posedge clk_in) c8 <= 1'b1;
      w(4);
      chk(c8off, 1'b1);
      @(posedge clk_in) {c8, uv, tie_hi, pull_lo, lvl} <= 6'h06;
      w(FC + RC + 8);
      chk({soff, st[2], dg}, 4'h8);
      $display("pin test done");
      end_sim();
   end
endmodule : supply_monitor_shutdown_tb
